// ==== rtl/prp_pkg.sv ====
// Package of the reset, power-down and shared interrupt pin controller.
// Assumes a 100 MHz system clock and a 16-bit register port.
package prp_pkg;

  // ---------------------------------------------------------------
  // Widths
  // ---------------------------------------------------------------
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 16;
  localparam int EVT_W   = 8;
  localparam int STRAP_W = 8;
  localparam int CNT_W   = 8;

  // ---------------------------------------------------------------
  // Register offsets (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_PIN_CFG    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_DEV_STATUS = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_REGULATOR  = 8'hD0;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int PIN_CFG_IRQ_ROLE_BIT = 0;
  localparam int REGU_OFF_BIT         = 0;
  localparam int DEV_PWR_DOWN_BIT     = 0;
  localparam int DEV_IRQ_ROLE_BIT     = 1;
  localparam int DEV_IRQ_PIN_BIT      = 2;
  localparam int DEV_STRAP_LSB        = 8;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic              IRQ_ROLE_RST = 1'b0;
  localparam logic [EVT_W-1:0]  IRQ_STS_RST  = 8'h00;
  localparam logic [EVT_W-1:0]  IRQ_MASK_RST = 8'h00;
  localparam logic [DATA_W-1:0] REGU_RST     = 16'h0000;
  localparam logic [STRAP_W-1:0] STRAP_RST   = 8'h00;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int RST_MIN_NS    = 1000;
  localparam int RST_MIN_CYC   = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_PROC_CYC  = 16;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    PRP_ST_INIT,
    PRP_ST_RUN,
    PRP_ST_HOLD
  } prp_phase_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } prp_bus_req_t;

  typedef struct packed {
    prp_phase_t         phase;
    logic [CNT_W-1:0]   cnt;
    logic               irq_role;
    logic [EVT_W-1:0]   sts;
    logic [EVT_W-1:0]   mask;
    logic [DATA_W-1:0]  regu;
    logic [STRAP_W-1:0] strap;
    logic [DATA_W-1:0]  rdata;
    logic               pin_oe;
    logic               pwr_down;
    logic               irq;
    logic               busy;
  } prp_state_t;

  localparam prp_state_t PRP_STATE_RST = '{
    phase:    PRP_ST_INIT,
    cnt:      8'h00,
    irq_role: IRQ_ROLE_RST,
    sts:      IRQ_STS_RST,
    mask:     IRQ_MASK_RST,
    regu:     REGU_RST,
    strap:    STRAP_RST,
    rdata:    16'h0000,
    pin_oe:   1'b0,
    pwr_down: 1'b0,
    irq:      1'b0,
    busy:     1'b1
  };

endpackage : prp_pkg

// ==== rtl/prp_ctrl.sv ====
// Reset sequencer, shared interrupt / power-down pin and regulator control.
// Assumes all inputs except RSTN_IN and TEST_RESET_N_IN synchronous to SYS_CLK_IN; the open-drain pin wire is
// resolved outside from the output enable.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps

// Functional notes
// - Reset pin low 1us starts reset process
// - Reset process returns all registers to init
// - Straps resampled on every reset process
// - Register bit selects shared pin role
// - Shared pin is power-down input after reset
// - Pin low in power-down role: power down
// - Interrupt role: pin pulled low on interrupt
// - Interrupt role drives only low, open-drain
// - Test port reset asynchronous on test reset
// - Regulator register write with bit 0 set turns regulator off
module prp_ctrl #(
  parameter int RST_MIN_CYC  = prp_pkg::RST_MIN_CYC,
  parameter int RST_PROC_CYC = prp_pkg::RST_PROC_CYC
) (
  input  wire logic                             SYS_CLK_IN,
  input  wire logic                             RSTN_IN,
  input  wire logic                             HW_RESET_N_IN,
  input  wire logic                             TEST_RESET_N_IN,
  input  wire logic [prp_pkg::STRAP_W-1:0]      STRAP_IN,
  input  wire logic [prp_pkg::EVT_W-1:0]        EVENT_IN,
  input  wire prp_pkg::prp_bus_req_t            BUS_REQ_IN,
  input  wire logic                             IRQ_OR_SLEEP_PIN_IN,
  output logic                                  IRQ_OR_SLEEP_PIN_OUT,
  output logic                                  IRQ_OR_SLEEP_PIN_OE_OUT,
  output logic                                  POWER_DOWN_OUT,
  output logic                                  REGULATOR_OFF_OUT,
  output logic                                  IRQ_OUT,
  output logic [prp_pkg::STRAP_W-1:0]           STRAP_OUT,
  output logic                                  RESET_BUSY_OUT,
  output logic [prp_pkg::DATA_W-1:0]            RD_DATA_OUT,
  output logic                                  TAP_RESET_OUT
);

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  localparam logic [prp_pkg::CNT_W-1:0] RST_MIN_LAST  =
    prp_pkg::CNT_W'(RST_MIN_CYC - 1);
  localparam logic [prp_pkg::CNT_W-1:0] RST_PROC_LAST =
    prp_pkg::CNT_W'(RST_PROC_CYC - 1);

  function automatic logic hit(input prp_pkg::prp_bus_req_t req,
                               input logic [prp_pkg::ADDR_W-1:0] ofs);
    hit = (req.addr == ofs);
  endfunction : hit

  function automatic logic [prp_pkg::DATA_W-1:0] widen_evt(
    input logic [prp_pkg::EVT_W-1:0] v);
    widen_evt = {{(prp_pkg::DATA_W - prp_pkg::EVT_W){1'b0}}, v};
  endfunction : widen_evt

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  prp_pkg::prp_state_t state_reg;
  prp_pkg::prp_state_t state_next;
  logic [1:0]          tap_rst_reg;

  // ---------------------------------------------------------------
  // Next-state logic
  // ---------------------------------------------------------------
  always_comb begin
    logic [prp_pkg::EVT_W-1:0]  sts_keep;
    logic [prp_pkg::DATA_W-1:0] dev_word;
    sts_keep   = state_reg.sts;
    dev_word   = '0;
    state_next = state_reg;
    state_next.rdata = '0;

    case (state_reg.phase)
      // Reset process: hold everything idle, then take the straps
      prp_pkg::PRP_ST_INIT: begin
        state_next.busy = 1'b1;
        state_next.cnt  = state_reg.cnt + 1'b1;
        if (state_reg.cnt >= RST_PROC_LAST) begin
          state_next.strap = STRAP_IN;
          state_next.cnt   = '0;
          state_next.busy  = 1'b0;
          state_next.phase = prp_pkg::PRP_ST_RUN;
        end
      end

      prp_pkg::PRP_ST_RUN: begin
        // Reset pin must stay low the full minimum before it counts
        if (!HW_RESET_N_IN) begin
          state_next.cnt = state_reg.cnt + 1'b1;
        end else begin
          state_next.cnt = '0;
        end

        // Register writes
        if (BUS_REQ_IN.wr) begin
          if (hit(BUS_REQ_IN, prp_pkg::OFS_PIN_CFG)) begin
            state_next.irq_role =
              BUS_REQ_IN.wdata[prp_pkg::PIN_CFG_IRQ_ROLE_BIT];
          end
          if (hit(BUS_REQ_IN, prp_pkg::OFS_IRQ_MASK)) begin
            state_next.mask = BUS_REQ_IN.wdata[prp_pkg::EVT_W-1:0];
          end
          if (hit(BUS_REQ_IN, prp_pkg::OFS_REGULATOR)) begin
            state_next.regu = BUS_REQ_IN.wdata;
          end
        end

        // Register reads, answered in the next cycle
        if (BUS_REQ_IN.rd) begin
          dev_word[prp_pkg::DEV_PWR_DOWN_BIT] = state_reg.pwr_down;
          dev_word[prp_pkg::DEV_IRQ_ROLE_BIT] = state_reg.irq_role;
          dev_word[prp_pkg::DEV_IRQ_PIN_BIT]  = state_reg.pin_oe;
          dev_word[prp_pkg::DEV_STRAP_LSB +: prp_pkg::STRAP_W] = state_reg.strap;
          case (BUS_REQ_IN.addr)
            prp_pkg::OFS_PIN_CFG: begin
              state_next.rdata[prp_pkg::PIN_CFG_IRQ_ROLE_BIT] = state_reg.irq_role;
            end
            prp_pkg::OFS_IRQ_STATUS: begin
              state_next.rdata = widen_evt(state_reg.sts);
              sts_keep         = '0;
            end
            prp_pkg::OFS_IRQ_MASK: begin
              state_next.rdata = widen_evt(state_reg.mask);
            end
            prp_pkg::OFS_DEV_STATUS: begin
              state_next.rdata = dev_word;
            end
            prp_pkg::OFS_REGULATOR: begin
              state_next.rdata = state_reg.regu;
            end
            default: begin
              state_next.rdata = '0;
            end
          endcase
        end

        // Sticky events: a new event wins over the read clear
        state_next.sts = sts_keep | EVENT_IN;

        // Reset pin held long enough: reinitialise every register
        if (!HW_RESET_N_IN && state_reg.cnt >= RST_MIN_LAST) begin
          state_next       = prp_pkg::PRP_STATE_RST;
          state_next.phase = prp_pkg::PRP_ST_HOLD;
        end
      end

      // Wait for the reset pin to rise, then run the reset process
      prp_pkg::PRP_ST_HOLD: begin
        state_next.busy = 1'b1;
        state_next.cnt  = '0;
        if (HW_RESET_N_IN) begin
          state_next.phase = prp_pkg::PRP_ST_INIT;
        end
      end

      default: begin
        state_next = prp_pkg::PRP_STATE_RST;
      end
    endcase

    // ---------------------------------------------------------------
    // Shared pin, interrupt and power-down outputs
    // ---------------------------------------------------------------
    state_next.irq = (state_next.phase == prp_pkg::PRP_ST_RUN) &&
                     (|(state_next.sts & state_next.mask));
    // Pulled low only while the condition stands, released otherwise
    state_next.pin_oe = state_next.irq_role && state_next.irq;
    // Power-down role is the default after any reset
    state_next.pwr_down = (state_next.phase == prp_pkg::PRP_ST_RUN) &&
                          !state_next.irq_role &&
                          !IRQ_OR_SLEEP_PIN_IN;
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      state_reg <= prp_pkg::PRP_STATE_RST;
    end else begin
      state_reg <= state_next;
    end
  end

  // Test port reset: asserts at once, releases after two clean clocks
  always_ff @(posedge SYS_CLK_IN or negedge TEST_RESET_N_IN or negedge RSTN_IN) begin
    if (!TEST_RESET_N_IN || !RSTN_IN) begin
      tap_rst_reg <= 2'h3;
    end else begin
      tap_rst_reg <= {tap_rst_reg[0], 1'b0};
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign IRQ_OR_SLEEP_PIN_OUT    = 1'b0;
  assign IRQ_OR_SLEEP_PIN_OE_OUT = state_reg.pin_oe;
  assign POWER_DOWN_OUT          = state_reg.pwr_down;
  assign REGULATOR_OFF_OUT       = state_reg.regu[prp_pkg::REGU_OFF_BIT];
  assign IRQ_OUT                 = state_reg.irq;
  assign STRAP_OUT               = state_reg.strap;
  assign RESET_BUSY_OUT          = state_reg.busy;
  assign RD_DATA_OUT             = state_reg.rdata;
  assign TAP_RESET_OUT           = tap_rst_reg[1];

endmodule : prp_ctrl

// ==== verif/prp_ctrl_sva.sv ====
// Assertions on the ports of the reset, power-down and shared pin controller.
// Assumes one clock domain; bound into every prp_ctrl instance.
`timescale 1ns/10ps
module prp_ctrl_sva #(
  parameter int RST_MIN_CYC = prp_pkg::RST_MIN_CYC
) (
  input wire logic                        SYS_CLK_IN,
  input wire logic                        RSTN_IN,
  input wire logic                        HW_RESET_N_IN,
  input wire logic                        TEST_RESET_N_IN,
  input wire logic [prp_pkg::STRAP_W-1:0] STRAP_IN,
  input wire logic [prp_pkg::EVT_W-1:0]   EVENT_IN,
  input wire prp_pkg::prp_bus_req_t       BUS_REQ_IN,
  input wire logic                        IRQ_OR_SLEEP_PIN_IN,
  input wire logic                        IRQ_OR_SLEEP_PIN_OUT,
  input wire logic                        IRQ_OR_SLEEP_PIN_OE_OUT,
  input wire logic                        POWER_DOWN_OUT,
  input wire logic                        REGULATOR_OFF_OUT,
  input wire logic                        IRQ_OUT,
  input wire logic [prp_pkg::STRAP_W-1:0] STRAP_OUT,
  input wire logic                        RESET_BUSY_OUT,
  input wire logic [prp_pkg::DATA_W-1:0]  RD_DATA_OUT,
  input wire logic                        TAP_RESET_OUT
);
  int low_cnt_reg;
  // Consecutive low samples of the hardware reset pin, saturating
  always_ff @(posedge SYS_CLK_IN or negedge RSTN_IN) begin
    if (!RSTN_IN) begin
      low_cnt_reg <= 0;
    end else if (HW_RESET_N_IN) begin
      low_cnt_reg <= 0;
    end else if (low_cnt_reg < RST_MIN_CYC) begin
      low_cnt_reg <= low_cnt_reg + 1;
    end
  end
  default clocking cb @(posedge SYS_CLK_IN); endclocking
  default disable iff (!RSTN_IN);
  a_hw_reset_taken: assert property (low_cnt_reg == RST_MIN_CYC |-> RESET_BUSY_OUT)
    else $error("hardware reset held long enough but no reset process");
  a_short_ignored: assert property ($rose(RESET_BUSY_OUT) |-> low_cnt_reg == RST_MIN_CYC)
    else $error("reset process started by a short reset pulse");
  a_busy_quiet: assert property (RESET_BUSY_OUT |-> !IRQ_OUT && !IRQ_OR_SLEEP_PIN_OE_OUT
    && !POWER_DOWN_OUT && !REGULATOR_OFF_OUT)
    else $error("output active during reset process");
  a_strap_capture: assert property ($fell(RESET_BUSY_OUT) |-> STRAP_OUT == $past(STRAP_IN))
    else $error("straps not resampled at end of reset");
  a_pd_source: assert property (POWER_DOWN_OUT |-> !$past(IRQ_OR_SLEEP_PIN_IN))
    else $error("power-down without the pin held low");
  a_oe_needs_irq: assert property (IRQ_OR_SLEEP_PIN_OE_OUT |-> IRQ_OUT)
    else $error("pin pulled without interrupt");
  a_drive_low_only: assert property (IRQ_OR_SLEEP_PIN_OUT == 1'b0)
    else $error("shared pin driven high");
  a_tap_async: assert property (!TEST_RESET_N_IN |-> TAP_RESET_OUT)
    else $error("test port not in reset");
  a_regu_write: assert property (BUS_REQ_IN.wr && !RESET_BUSY_OUT
    && BUS_REQ_IN.addr == prp_pkg::OFS_REGULATOR
    |=> REGULATOR_OFF_OUT == $past(BUS_REQ_IN.wdata[0]))
    else $error("regulator output does not follow write");
  a_irq_release: assert property (BUS_REQ_IN.rd && !RESET_BUSY_OUT && EVENT_IN == 8'h00
    && BUS_REQ_IN.addr == prp_pkg::OFS_IRQ_STATUS
    |=> !IRQ_OUT && !IRQ_OR_SLEEP_PIN_OE_OUT)
    else $error("interrupt still active after status read");
  a_rdata_idle: assert property (!$past(BUS_REQ_IN.rd) |-> RD_DATA_OUT == 16'h0000)
    else $error("read data outside read answer cycle");
endmodule : prp_ctrl_sva
bind prp_ctrl prp_ctrl_sva #(.RST_MIN_CYC(RST_MIN_CYC)) u_sva (.*);

// ==== verif/prp_host_model.sv ====
// Host side of the shared pin: pull-up wire, device open drain, host pull-down.
// Assumes the host pull request comes from the bench.
`timescale 1ns/10ps
module prp_host_model (
  input  wire logic pin_oe_in,
  input  wire logic pin_data_in,
  input  wire logic host_pull_in,
  output logic      pin_level_out
);
  assign pin_level_out = !((pin_oe_in && !pin_data_in) || host_pull_in);
endmodule : prp_host_model

// ==== verif/test_phy_reset_powerdown_irq_pin.sv ====
// Bench of the reset, power-down and shared interrupt pin controller.
// Assumes a 100 MHz clock and a short reset filter in simulation.
`timescale 1ns/10ps
module test_phy_reset_powerdown_irq_pin;
  logic clk = 0, rstn = 0, hw_n = 1, tst_n = 1, pull = 0;
  logic [7:0] strap = 8'h3C, evt = 8'h00, strap_o;
  prp_pkg::prp_bus_req_t req = '0;
  logic oe, pdo, lvl, pd, regu, irq, busy, tap;
  logic [15:0] rdq;
  int miscompares = 0, checks_done = 0, cycles = 0;
  always #5 clk = ~clk;
  prp_ctrl #(.RST_MIN_CYC(4)) dut (.SYS_CLK_IN(clk), .RSTN_IN(rstn), .HW_RESET_N_IN(hw_n),
    .TEST_RESET_N_IN(tst_n), .STRAP_IN(strap), .EVENT_IN(evt), .BUS_REQ_IN(req),
    .IRQ_OR_SLEEP_PIN_IN(lvl), .IRQ_OR_SLEEP_PIN_OUT(pdo), .IRQ_OR_SLEEP_PIN_OE_OUT(oe),
    .POWER_DOWN_OUT(pd), .REGULATOR_OFF_OUT(regu), .IRQ_OUT(irq), .STRAP_OUT(strap_o),
    .RESET_BUSY_OUT(busy), .RD_DATA_OUT(rdq), .TAP_RESET_OUT(tap));
  prp_host_model host (.pin_oe_in(oe), .pin_data_in(pdo), .host_pull_in(pull),
    .pin_level_out(lvl));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk) req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk) req <= '0;
    #1;
  endtask : wr
  task automatic rdchk(input string nm, input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk) req <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge clk) req <= '0;
    #1 chk(nm, exp, rdq);
  endtask : rdchk
  task automatic idle();
    repeat (40) if (busy !== 1'b0) @(posedge clk) #1;
    chk("busy", 16'h0000, busy);
  endtask : idle
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    cycles++;
    if (cycles >= 5000) begin
      miscompares++;
      complete_run();
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rstn <= 1;
    idle();
    chk("straps", 16'h003C, strap_o);
    rdchk("regulator", 8'hD0, 16'h0000);
    rdchk("pin_cfg", 8'h00, 16'h0000);
    rdchk("unmapped", 8'h20, 16'h0000);
    @(posedge clk) pull <= 1;
    repeat (2) @(posedge clk) #1;
    chk("pwr_down", 16'h0001, pd);
    @(posedge clk) pull <= 0;
    repeat (2) @(posedge clk) #1;
    chk("pwr_down", 16'h0000, pd);
    wr(8'hD0, 16'h0001);
    chk("regu_off", 16'h0001, regu);
    rdchk("regulator", 8'hD0, 16'h0001);
    wr(8'h08, 16'h0001);
    wr(8'h00, 16'h0001);
    rdchk("pin_cfg", 8'h00, 16'h0001);
    rdchk("irq_mask", 8'h08, 16'h0001);
    @(posedge clk) evt <= 8'h03;
    @(posedge clk) evt <= 8'h00;
    #1 chk("irq", 16'h0001, irq);
    chk("pin_level", 16'h0000, lvl);
    rdchk("dev_status", 8'h0C, 16'h3C06);
    rdchk("irq_status", 8'h04, 16'h0003);
    chk("irq", 16'h0000, irq);
    chk("pin_level", 16'h0001, lvl);
    @(posedge clk) pull <= 1;
    repeat (2) @(posedge clk) #1;
    chk("pwr_down", 16'h0000, pd);
    @(posedge clk) pull <= 0;
    strap <= 8'hA5;
    hw_n <= 0;
    repeat (3) @(posedge clk);
    hw_n <= 1;
    repeat (2) @(posedge clk) #1;
    chk("busy", 16'h0000, busy);
    @(posedge clk) hw_n <= 0;
    repeat (6) @(posedge clk) #1;
    chk("busy", 16'h0001, busy);
    @(posedge clk) hw_n <= 1;
    idle();
    chk("straps", 16'h00A5, strap_o);
    rdchk("dev_status", 8'h0C, 16'hA500);
    chk("regu_off", 16'h0000, regu);
    rdchk("pin_cfg", 8'h00, 16'h0000);
    @(posedge clk) tst_n <= 0;
    #1 chk("tap", 16'h0001, tap);
    @(posedge clk) tst_n <= 1;
    repeat (3) @(posedge clk) #1;
    chk("tap", 16'h0000, tap);
    complete_run();
  end
endmodule : test_phy_reset_powerdown_irq_pin
